// >>> design/irq_flag_bank.sv
// Per-lane interrupt flags for the shared status register.
// Assumes lane interrupt sources are synchronous to clk_sys.
`timescale 1ns/1ps

module irq_flag_bank #(
  parameter int N = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic         clear_all,
  input  wire logic [N-1:0] irq_in,
  output logic      [N-1:0] flags
);

  // Set wins over a bank reset in the same cycle
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          flags[g] <= 1'b0;
        end else if (clk_en) begin
          if (irq_in[g]) begin
            flags[g] <= 1'b1;
          end else if (clear_all) begin
            flags[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule : irq_flag_bank

// >>> design/shared_regs_channel_select.sv
// Shared register bank with channel select steering for a four-lane retimer.
// Assumes a single-cycle byte register port from the serial bus slave.
`timescale 1ns/1ps

module shared_regs_channel_select #(
  parameter int NUM_LANES = shared_regs_pkg::NUM_LANES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // Straps, sampled through two flops
  input  wire logic [3:0]           strap_addr,
  // Register port
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  output logic      [6:0]           bus_addr,
  // Lane register sets
  output logic      [NUM_LANES-1:0] lane_wr,
  output logic                      lane_rd,
  output logic      [1:0]           lane_rd_sel,
  output logic      [7:0]           lane_addr,
  output logic      [7:0]           lane_wdata,
  input  wire logic [7:0]           lane_rdata,
  // Lane interrupts and config engine
  input  wire logic [NUM_LANES-1:0] lane_irq,
  input  wire logic                 cfg_load_done,
  output logic                      config_master_reset,
  output logic                      force_config_load,
  output logic                      cfg_load_enable
);

  ////////////////////////////////////////////////////////////////////////
  // Strap synchroniser

  logic [3:0] strap_meta_r;
  logic [3:0] strap_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_meta_r <= 4'h0;
      strap_r      <= 4'h0;
    end else if (clk_en) begin
      strap_meta_r <= strap_addr;
      strap_r      <= strap_meta_r;
    end
  end

  assign bus_addr = shared_regs_pkg::BUS_ADDR_BASE + {3'h0, strap_r};

  ////////////////////////////////////////////////////////////////////////
  // Done flag synchroniser: the config engine may run on its own clock

  logic done_meta_r;
  logic done_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_meta_r <= 1'b1;
      done_r      <= 1'b1;
    end else if (clk_en) begin
      done_meta_r <= cfg_load_done;
      done_r      <= done_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [7:0] select_r;
  logic [7:0] rstctl_r;
  logic [7:0] status_cfg_r;
  logic [7:0] spare2_r;
  logic [7:0] spare6_r;
  logic [7:0] spare7_r;
  logic       bank_reset_r;
  logic       master_reset_r;

  wire        hit_select   = (reg_addr == shared_regs_pkg::ADDR_SELECT);
  wire        lane_mode    = select_r[shared_regs_pkg::BIT_LANE_EN];
  wire        broadcast    = select_r[shared_regs_pkg::BIT_BROADCAST];
  wire [1:0]  lane_sel     = select_r[1:0];
  wire        to_lanes     = lane_mode && !hit_select;
  wire        shared_wr    = reg_wr && !to_lanes;
  wire        wr_select    = reg_wr && hit_select;
  wire        wr_rstctl    = shared_wr && (reg_addr == shared_regs_pkg::ADDR_RSTCTL);
  wire        wr_status    = shared_wr && (reg_addr == shared_regs_pkg::ADDR_STATUS);
  wire        wr_spare2    = shared_wr && (reg_addr == shared_regs_pkg::ADDR_SPARE2);
  wire        wr_spare6    = shared_wr && (reg_addr == shared_regs_pkg::ADDR_SPARE6);
  wire        wr_spare7    = shared_wr && (reg_addr == shared_regs_pkg::ADDR_SPARE7);
  wire        do_bank_rst  = wr_rstctl && reg_wdata[shared_regs_pkg::BIT_BANK_RESET];

  ////////////////////////////////////////////////////////////////////////
  // Lane write fan-out

  function automatic logic [NUM_LANES-1:0] lane_onehot(input logic [1:0] sel);
    logic [NUM_LANES-1:0] v;
    v = '0;
    v[sel] = 1'b1;
    return v;
  endfunction : lane_onehot

  wire lane_wr_go = reg_wr && to_lanes && clk_en;

  assign lane_wr     = !lane_wr_go ? '0 :
                       broadcast   ? '1 :
                                     lane_onehot(lane_sel);
  assign lane_rd     = reg_rd && to_lanes && clk_en;
  assign lane_rd_sel = lane_sel;
  assign lane_addr   = reg_addr;
  assign lane_wdata  = reg_wdata;

  ////////////////////////////////////////////////////////////////////////
  // Shared registers

  // Select register is not cleared by the bank reset so steering is kept
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      select_r <= shared_regs_pkg::RST_SELECT;
    end else if (clk_en && wr_select) begin
      select_r <= reg_wdata;
    end
  end

  wire [7:0] rstctl_nxt = (rstctl_r & ~shared_regs_pkg::MASK_RSTCTL_RW)
                        | (reg_wdata & shared_regs_pkg::MASK_RSTCTL_RW);
  wire [7:0] status_nxt = (status_cfg_r & ~shared_regs_pkg::MASK_STATUS_RW)
                        | (reg_wdata & shared_regs_pkg::MASK_STATUS_RW);

  always_ff @(posedge clk_sys) begin
    if (rst || (clk_en && bank_reset_r)) begin
      rstctl_r     <= shared_regs_pkg::RST_RSTCTL;
      status_cfg_r <= shared_regs_pkg::RST_STATUS_CFG;
      spare2_r     <= shared_regs_pkg::RST_SPARE;
      spare6_r     <= shared_regs_pkg::RST_SPARE;
      spare7_r     <= shared_regs_pkg::RST_SPARE7;
    end else if (clk_en) begin
      if (wr_rstctl) begin
        rstctl_r <= rstctl_nxt;
      end
      if (wr_status) begin
        status_cfg_r <= status_nxt;
      end
      if (wr_spare2) begin
        spare2_r <= reg_wdata;
      end
      if (wr_spare6) begin
        spare6_r <= reg_wdata;
      end
      if (wr_spare7) begin
        spare7_r <= reg_wdata;
      end
    end
  end

  // Self-clearing strobes: one cycle each
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bank_reset_r   <= 1'b0;
      master_reset_r <= 1'b0;
    end else if (clk_en) begin
      bank_reset_r   <= do_bank_rst;
      master_reset_r <= wr_rstctl && reg_wdata[shared_regs_pkg::BIT_MASTER_RESET];
    end
  end

  assign config_master_reset = master_reset_r;
  assign force_config_load   = rstctl_r[shared_regs_pkg::BIT_FORCE_LOAD];
  assign cfg_load_enable     = !status_cfg_r[shared_regs_pkg::BIT_CFG_DISABLE];

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags

  logic [NUM_LANES-1:0] irq_flags;

  irq_flag_bank #(
    .N (NUM_LANES)
  ) u_irq (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clk_en    (clk_en),
    .clear_all (bank_reset_r),
    .irq_in    (lane_irq),
    .flags     (irq_flags)
  );

  // Lane 0 sits in bit 3, lane 3 in bit 0
  logic [3:0] irq_view;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LANES; gi++) begin : g_irq_view
      assign irq_view[3-gi] = irq_flags[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read mux: registered data, one cycle after the read strobe

  wire [7:0] strap_view  = {strap_r, 4'h0};
  wire [7:0] status_view = {status_cfg_r[7:5], done_r, irq_view};
  wire [7:0] shared_rd_val =
    (reg_addr == shared_regs_pkg::ADDR_STRAP)  ? strap_view :
    (reg_addr == shared_regs_pkg::ADDR_IDENT)  ? shared_regs_pkg::IDENT_DEFAULT :
    (reg_addr == shared_regs_pkg::ADDR_SPARE2) ? spare2_r :
    (reg_addr == shared_regs_pkg::ADDR_RSTCTL) ? rstctl_r :
    (reg_addr == shared_regs_pkg::ADDR_STATUS) ? status_view :
    (reg_addr == shared_regs_pkg::ADDR_SPARE6) ? spare6_r :
    (reg_addr == shared_regs_pkg::ADDR_SPARE7) ? spare7_r :
                                                 shared_regs_pkg::READ_ZERO;
  // Select register reads as zero; host must not rely on it
  wire [7:0] rd_val = hit_select ? shared_regs_pkg::READ_ZERO :
                      to_lanes   ? lane_rdata : shared_rd_val;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= shared_regs_pkg::READ_ZERO;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_val;
    end
  end

endmodule : shared_regs_channel_select

// >>> include/shared_regs_pkg.sv
// Constants for the shared register bank and channel select steering.
// Assumes a byte-wide register port driven by the serial bus slave logic.
package shared_regs_pkg;

  localparam int          NUM_LANES        = 4;
  localparam int          LANE_SEL_W       = 2;

  // Offsets
  localparam logic [7:0]  ADDR_STRAP       = 8'h00;
  localparam logic [7:0]  ADDR_IDENT       = 8'h01;
  localparam logic [7:0]  ADDR_SPARE2      = 8'h02;
  localparam logic [7:0]  ADDR_SPARE3      = 8'h03;
  localparam logic [7:0]  ADDR_RSTCTL      = 8'h04;
  localparam logic [7:0]  ADDR_STATUS      = 8'h05;
  localparam logic [7:0]  ADDR_SPARE6      = 8'h06;
  localparam logic [7:0]  ADDR_SPARE7      = 8'h07;
  localparam logic [7:0]  ADDR_SELECT      = 8'hff;

  // Reset values
  localparam logic [7:0]  RST_RSTCTL       = 8'h01;
  localparam logic [7:0]  RST_STATUS_CFG   = 8'h00;
  localparam logic [7:0]  RST_SPARE        = 8'h00;
  localparam logic [7:0]  RST_SPARE7       = 8'h05;
  localparam logic [7:0]  RST_SELECT       = 8'h00;
  localparam logic [7:0]  READ_ZERO        = 8'h00;
  // Arbitrary identity value
  localparam logic [7:0]  IDENT_DEFAULT    = 8'h5a;

  // Bus address base
  localparam logic [6:0]  BUS_ADDR_BASE    = 7'h18;

  // Field positions
  localparam int          STRAP_LSB        = 4;
  localparam int          BIT_BANK_RESET   = 6;
  localparam int          BIT_MASTER_RESET = 5;
  localparam int          BIT_FORCE_LOAD   = 4;
  localparam int          BIT_CFG_DISABLE  = 7;
  localparam int          BIT_LOAD_DONE    = 4;
  localparam int          BIT_BROADCAST    = 3;
  localparam int          BIT_LANE_EN      = 2;

  // Writable masks
  localparam logic [7:0]  MASK_RSTCTL_RW   = 8'h9f;
  localparam logic [7:0]  MASK_STATUS_RW   = 8'he0;

endpackage : shared_regs_pkg

// >>> verif/lane_sets_model.sv
// Behavioural lane register sets behind the shared bank.
// Assumes lane strobes arrive in the clk_sys domain.
`timescale 1ns/1ps
module lane_sets_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] lane_wr,
  input  wire logic       lane_rd,
  input  wire logic [1:0] lane_rd_sel,
  input  wire logic [7:0] lane_addr,
  input  wire logic [7:0] lane_wdata,
  output logic      [7:0] lane_rdata
);
  // Eight bytes a lane; upper address bits alias to save space
  logic [7:0] mem [4][8];
  wire  [7:0] held = mem[lane_rd_sel][lane_addr[2:0]];
  //////////////////////////////
  // Inverse when not read, so stale data never passes
  assign lane_rdata = lane_rd ? held : ~held;
  always @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (lane_wr[i]) mem[i][lane_addr[2:0]] <= lane_wdata;
    end
  end
endmodule : lane_sets_model

// >>> verif/regs_chk.sv
// Port assertions for the shared bank and lane steering.
// Assumes binding onto shared_regs_channel_select.
`timescale 1ns/1ps
module regs_chk #(
  parameter int NUM_LANES = 4
) (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 clk_en,
  input wire logic [3:0]           strap_addr,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic [7:0]           reg_rdata,
  input wire logic [6:0]           bus_addr,
  input wire logic [NUM_LANES-1:0] lane_wr,
  input wire logic                 lane_rd,
  input wire logic [1:0]           lane_rd_sel,
  input wire logic [7:0]           lane_rdata,
  input wire logic                 config_master_reset,
  input wire logic                 force_config_load,
  input wire logic                 cfg_load_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Shadow of the select register; bank reset leaves it alone
  logic [7:0] sel_r;
  wire        lane_acc = clk_en && reg_addr != 8'hff && sel_r[2];
  wire        sh_wr    = clk_en && reg_wr && !sel_r[2];
  //////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) sel_r <= 8'h00;
    else if (clk_en && reg_wr && reg_addr == 8'hff) sel_r <= reg_wdata;
  end
  a_bcast_all: assert property (lane_acc && reg_wr && sel_r[3] |-> lane_wr == 4'hf)
    else $error("broadcast write missed a lane");
  a_sel_write: assert property (reg_wr && reg_addr == 8'hff |-> lane_wr == 4'h0)
    else $error("select write reached a lane");
  a_shared_only: assert property (!sel_r[2] |-> lane_wr == 4'h0 && !lane_rd)
    else $error("lane access while lanes disabled");
  a_one_lane: assert property (lane_acc && reg_wr && !sel_r[3] |-> lane_wr == 4'h1 << sel_r[1:0])
    else $error("single write hit wrong lane");
  a_rd_target: assert property (lane_rd_sel == sel_r[1:0])
    else $error("read lane differs from select");
  a_lane_read: assert property (lane_acc && reg_rd |-> lane_rd ##1 reg_rdata == $past(lane_rdata))
    else $error("lane read data lost");
  a_strap_addr: assert property ((clk_en && $stable(strap_addr))[*5] |-> bus_addr == 7'h18 + strap_addr)
    else $error("bus address wrong");
  a_master_pulse: assert property (sh_wr && reg_addr == 8'h04 && reg_wdata[5] |=> config_master_reset)
    else $error("master reset pulse missing");
  a_force_load: assert property (sh_wr && reg_addr == 8'h04 |=> force_config_load == $past(reg_wdata[4]))
    else $error("force load wrong");
  a_cfg_block: assert property (sh_wr && reg_addr == 8'h05 |=> cfg_load_enable == !$past(reg_wdata[7]))
    else $error("config load enable wrong");
endmodule : regs_chk
bind shared_regs_channel_select regs_chk #(.NUM_LANES(NUM_LANES)) chk_u (.*);

// >>> verif/tb.sv
// Self-checking bench for the shared bank and lane steering.
// Assumes the lane model and checker compile ahead of it.
`timescale 1ns/1ps
module tb;
  logic       clk_sys, rst, clk_en, reg_wr, reg_rd, lane_rd, cfg_load_done;
  logic       config_master_reset, force_config_load, cfg_load_enable;
  logic [1:0] lane_rd_sel;
  logic [3:0] strap_addr, lane_wr, lane_irq;
  logic [6:0] bus_addr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lane_addr, lane_wdata, lane_rdata;
  int         fails = 0, total_checks = 0;
  shared_regs_channel_select dut_u (.clk_sys, .rst, .clk_en, .strap_addr, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .bus_addr, .lane_wr, .lane_rd, .lane_rd_sel, .lane_addr,
    .lane_wdata, .lane_rdata, .lane_irq, .cfg_load_done, .config_master_reset,
    .force_config_load, .cfg_load_enable);
  lane_sets_model lane_u (.clk_sys, .lane_wr, .lane_rd, .lane_rd_sel, .lane_addr, .lane_wdata,
    .lane_rdata);
  //////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #2;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys) #2;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys) #2;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys) #2;
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  //////////////////////////////
  task automatic t_defaults();
    rd(8'h01, shared_regs_pkg::IDENT_DEFAULT);
    rd(8'h04, 8'h01);
    rd(8'h05, 8'h10);
    rd(8'h07, 8'h05);
    rd(8'h00, 8'h90);
    chk({1'b0, bus_addr}, 8'h21);
  endtask : t_defaults
  task automatic t_read_only();
    wr(8'h00, 8'hff);
    wr(8'h01, 8'h00);
    wr(8'h05, 8'hff);
    rd(8'h00, 8'h90);
    rd(8'h01, shared_regs_pkg::IDENT_DEFAULT);
    rd(8'h05, 8'hf0);
    chk({7'h0, cfg_load_enable}, 8'h00);
    wr(8'h05, 8'h00);
    chk({7'h0, cfg_load_enable}, 8'h01);
  endtask : t_read_only
  task automatic t_flags_reset();
    cfg_load_done = 1'b0;
    @(posedge clk_sys) #2;
    lane_irq = 4'b0001;
    @(posedge clk_sys) #2;
    lane_irq = 4'b1000;
    @(posedge clk_sys) #2;
    lane_irq = 4'h0;
    rd(8'h05, 8'h09);
    cfg_load_done = 1'b1;
    wr(8'h07, 8'h33);
    wr(8'h02, 8'h5c);
    wr(8'h06, 8'hc3);
    wr(8'h04, 8'h9e);
    rd(8'h04, 8'h9e);
    rd(8'h07, 8'h33);
    rd(8'h02, 8'h5c);
    rd(8'h06, 8'hc3);
    wr(8'h04, 8'h40);
    rd(8'h04, 8'h01);
    rd(8'h02, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h05, 8'h10);
    rd(8'h07, 8'h05);
  endtask : t_flags_reset
  task automatic t_master();
    wr(8'h04, 8'h30);
    chk({7'h0, config_master_reset}, 8'h01);
    chk({7'h0, force_config_load}, 8'h01);
    rd(8'h04, 8'h10);
    chk({7'h0, config_master_reset}, 8'h00);
    wr(8'h04, 8'h01);
  endtask : t_master
  task automatic t_lanes();
    for (int i = 0; i < 4; i++) begin
      wr(8'hff, 8'h04 | i[7:0]);
      wr(8'h10, 8'ha0 | i[7:0]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'hff, 8'h04 | i[7:0]);
      rd(8'h10, 8'ha0 | i[7:0]);
    end
    wr(8'hff, 8'h0e);
    wr(8'h10, 8'h77);
    for (int i = 0; i < 4; i++) begin
      wr(8'hff, 8'h0c | i[7:0]);
      rd(8'h10, 8'h77);
    end
    wr(8'hff, 8'h00);
    rd(8'h04, 8'h01);
    wr(8'h10, 8'h55);
    wr(8'hff, 8'h06);
    rd(8'h10, 8'h77);
  endtask : t_lanes
  //////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Whole run is about 130 cycles; this span of 2000 cycles is generous
  initial begin
    #50000;
    fails++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    strap_addr = 4'h9;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    lane_irq = 4'h0;
    cfg_load_done = 1'b1;
    repeat (8) @(posedge clk_sys);
    #2 rst = 1'b0;
    t_defaults();
    t_read_only();
    t_flags_reset();
    t_master();
    t_lanes();
    give_verdict();
  end
endmodule : tb
